// ==== core/aowlc_defs.svh ====
// constants for the output word and lane configuration block
// assumes a host writes registers through a simple strobed address/data port
`ifndef AOWLC_DEFS_SVH
`define AOWLC_DEFS_SVH
`define AOWLC_ADDR_W        9
`define AOWLC_ADDR_IN_PROTO 9'h014
`define AOWLC_ADDR_OUT_PROTO 9'h018
`define AOWLC_ADDR_WORD_CFG 9'h01C
`define AOWLC_RST_BYTE      8'h00
`define AOWLC_OUT_PROTO_WMASK 8'hDF
`define AOWLC_WORD_CFG_WMASK  8'h3F
`define AOWLC_IN_PROTO_WMASK  8'h03
`define AOWLC_MODE_SPI      2'h0
`define AOWLC_MODE_SSYNC    2'h3
`define AOWLC_WORD_W        20
`define AOWLC_DATA_W        16
`define AOWLC_LANES         4
`define AOWLC_DIV_W         3
`define AOWLC_DIV2_TAP      1
`define AOWLC_DIV4_TAP      2
`define AOWLC_PAT_ZEROS     16'h0000
`define AOWLC_PAT_ONES      16'hFFFF
`define AOWLC_PAT_ALT1      16'h5555
`define AOWLC_PAT_ALT2      16'h3333
`endif

// ==== core/aowlc_pkg.sv ====
// types shared by the output word and lane configuration block
// assumes aowlc_defs.svh is on the include path
package aowlc_pkg;
   typedef enum logic [1:0] {
      AOWLC_CLK_ECHO,
      AOWLC_CLK_INT,
      AOWLC_CLK_INT_DIV2,
      AOWLC_CLK_INT_DIV4
   } aowlc_clk_sel_e;
   typedef enum logic [1:0] {
      AOWLC_SPAN_4,
      AOWLC_SPAN_8,
      AOWLC_SPAN_12,
      AOWLC_SPAN_16
   } aowlc_span_e;
endpackage : aowlc_pkg

// ==== core/aowlc_word_fmt.sv ====
// output word formatter: pattern select and even parity append
// assumes conversion result is stable for the cycle it is sampled
`timescale 1ns/1ps
`include "aowlc_defs.svh"
module aowlc_word_fmt (
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic [`AOWLC_DATA_W-1:0]  conv_result,
   input  wire logic [2:0]                test_pattern_select,
   input  wire logic                      parity_append_enable,
   input  wire aowlc_pkg::aowlc_span_e    partial_parity_span,
   output logic      [`AOWLC_WORD_W-1:0]  out_word
);
   import aowlc_pkg::*;
   logic [`AOWLC_DATA_W-1:0] body;
   logic                     full_parity_bit;
   logic                     partial_parity_bit;

   // data field of the word: result or fixed pattern
   always_comb begin
      case (test_pattern_select)
         3'h4:    body = `AOWLC_PAT_ZEROS;
         3'h5:    body = `AOWLC_PAT_ONES;
         3'h6:    body = `AOWLC_PAT_ALT1;
         3'h7:    body = `AOWLC_PAT_ALT2;
         default: body = conv_result;
      endcase
   end

   // even parity over the whole data field and over the chosen msb span of it
   always_comb begin
      full_parity_bit = ^body;
      case (partial_parity_span)
         AOWLC_SPAN_4:  partial_parity_bit = ^body[15:12];
         AOWLC_SPAN_8:  partial_parity_bit = ^body[15:8];
         AOWLC_SPAN_12: partial_parity_bit = ^body[15:4];
         default:       partial_parity_bit = ^body;
      endcase
   end

   // registered word; low two bits have no defined use so stay zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_word <= '0;
      end else begin
         out_word <= {body,
                      parity_append_enable & full_parity_bit,
                      parity_append_enable & partial_parity_bit,
                      2'h0};
      end
   end

   a_parity_off_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !parity_append_enable |=> out_word[3:2] == 2'h0)
      else $error("parity bits set while parity disabled");
   a_full_parity_even: assert property (@(posedge ref_clk) disable iff (!rst_n)
      parity_append_enable |=> ^out_word[19:3] == 1'b0)
      else $error("full parity not even");
   a_low_bits_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ##1 out_word[1:0] == 2'h0)
      else $error("word low bits not zero");
   a_pattern_alt: assert property (@(posedge ref_clk) disable iff (!rst_n)
      test_pattern_select == 3'h6 |=> out_word[19:4] == `AOWLC_PAT_ALT1)
      else $error("alternating pattern wrong");
endmodule : aowlc_word_fmt

// ==== core/aowlc_top.sv ====
// output word and lane configuration: register bank, word formatter, lane and clock select
// assumes a host writes registers through a byte-wide strobed config port, reads combinational
`timescale 1ns/1ps
`include "aowlc_defs.svh"
module aowlc_top (
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   input  wire logic                      cfg_wr,
   input  wire logic                      cfg_rd,
   input  wire logic [`AOWLC_ADDR_W-1:0]  cfg_addr,
   input  wire logic [7:0]                cfg_wdata,
   output logic      [7:0]                cfg_rdata,
   input  wire logic [`AOWLC_DATA_W-1:0]  conv_result,
   input  wire logic                      sclk_echo_in,
   output logic      [`AOWLC_WORD_W-1:0]  out_word,
   output logic      [`AOWLC_LANES-1:0]   lane_enable,
   output logic                           source_sync_mode,
   output logic                           double_rate,
   output logic                           out_clk_sel_echo,
   output logic                           out_clk,
   output logic                           spi_cpol,
   output logic                           spi_cpha
);
   import aowlc_pkg::*;
   logic       rst_s1_r;
   logic       rst_n;
   logic [7:0] in_proto_r;
   logic [7:0] out_proto_r;
   logic [7:0] word_cfg_r;
   logic [`AOWLC_DIV_W-1:0] div_cnt_r;
   logic [1:0] output_protocol_select;
   logic [1:0] output_lane_count;
   aowlc_clk_sel_e source_sync_clock_select;
   logic       addr_unmapped;

   // reset release through two flops so deassertion is clean
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // register writes; read-only positions are masked so they stay zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_proto_r  <= `AOWLC_RST_BYTE;
         out_proto_r <= `AOWLC_RST_BYTE;
         word_cfg_r  <= `AOWLC_RST_BYTE;
      end else if (cfg_wr) begin
         case (cfg_addr)
            `AOWLC_ADDR_IN_PROTO:  in_proto_r  <= cfg_wdata & `AOWLC_IN_PROTO_WMASK;
            `AOWLC_ADDR_OUT_PROTO: out_proto_r <= cfg_wdata & `AOWLC_OUT_PROTO_WMASK;
            `AOWLC_ADDR_WORD_CFG:  word_cfg_r  <= cfg_wdata & `AOWLC_WORD_CFG_WMASK;
            default: ;
         endcase
      end
   end

   // combinational read-back; unmapped addresses read zero
   always_comb begin
      cfg_rdata = 8'h00;
      if (cfg_rd) begin
         case (cfg_addr)
            `AOWLC_ADDR_IN_PROTO:  cfg_rdata = in_proto_r;
            `AOWLC_ADDR_OUT_PROTO: cfg_rdata = out_proto_r;
            `AOWLC_ADDR_WORD_CFG:  cfg_rdata = word_cfg_r;
            default:               cfg_rdata = 8'h00;
         endcase
      end
   end

   // field decode
   assign output_protocol_select   = out_proto_r[1:0];
   assign output_lane_count        = out_proto_r[3:2];
   assign source_sync_clock_select = aowlc_clk_sel_e'(out_proto_r[7:6]);
   // helper for the address checks: none of the three register slots
   assign addr_unmapped            = cfg_addr != `AOWLC_ADDR_IN_PROTO &&
                                     cfg_addr != `AOWLC_ADDR_OUT_PROTO &&
                                     cfg_addr != `AOWLC_ADDR_WORD_CFG;

   // protocol and spi mode outputs; unsupported codes 01/10 left to the host to avoid
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         source_sync_mode <= 1'b0;
         double_rate      <= 1'b0;
         spi_cpol         <= 1'b0;
         spi_cpha         <= 1'b0;
      end else begin
         source_sync_mode <= (output_protocol_select == `AOWLC_MODE_SSYNC);
         double_rate      <= (output_protocol_select == `AOWLC_MODE_SSYNC)
                             & out_proto_r[4];
         spi_cpol         <= in_proto_r[1];
         spi_cpha         <= in_proto_r[0];
      end
   end

   // lane enables, one per lane
   genvar g;
   generate
      for (g = 0; g < `AOWLC_LANES; g = g + 1) begin : g_lane
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               lane_enable[g] <= (g == 0);
            end else begin
               lane_enable[g] <= (g == 0) ||
                                 (output_lane_count == 2'h2 && g < 2) ||
                                 (output_lane_count == 2'h3);
            end
         end
      end
   endgenerate

   // internal clock divider; free-running so divided clocks stay phase steady
   // tap 1 toggles every 2 edges and tap 2 every 4, giving the /2 and /4 choices
   // relative to the plain internal choice, which toggles out_clk every edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + `AOWLC_DIV_W'(1);
      end
   end

   // output clock source; echo is passed through, /2 and /4 choices from the divider, plain internal choice self-toggles
   // selection is not gated by the protocol field: outside source-sync mode the
   // clock is simply unused, which keeps a mux off the clock path
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_clk          <= 1'b0;
         out_clk_sel_echo <= 1'b0;
      end else begin
         out_clk_sel_echo <= source_sync_mode && source_sync_clock_select == AOWLC_CLK_ECHO;
         case (source_sync_clock_select)
            AOWLC_CLK_ECHO:     out_clk <= sclk_echo_in;
            AOWLC_CLK_INT:      out_clk <= ~out_clk;
            AOWLC_CLK_INT_DIV2: out_clk <= div_cnt_r[`AOWLC_DIV2_TAP];
            AOWLC_CLK_INT_DIV4: out_clk <= div_cnt_r[`AOWLC_DIV4_TAP];
            default:            out_clk <= 1'b0;
         endcase
      end
   end

   // output word assembly
   aowlc_word_fmt u_fmt (
      .ref_clk              (ref_clk),
      .rst_n                (rst_n),
      .conv_result          (conv_result),
      .test_pattern_select  (word_cfg_r[2:0]),
      .parity_append_enable (word_cfg_r[3]),
      .partial_parity_span  (aowlc_span_e'(word_cfg_r[5:4])),
      .out_word             (out_word)
   );

   // register bank checks: masks, address decode and the combinational read port
   // reserved positions are masked at write time, so they must never show up in
   // either the stored byte or the read-back byte
   sequence s_wr_word;
      cfg_wr && cfg_addr == `AOWLC_ADDR_WORD_CFG;
   endsequence
   sequence s_wr_out_proto;
      cfg_wr && cfg_addr == `AOWLC_ADDR_OUT_PROTO;
   endsequence
   sequence s_wr_in_proto;
      cfg_wr && cfg_addr == `AOWLC_ADDR_IN_PROTO;
   endsequence
   sequence s_wr_unmapped;
      cfg_wr && addr_unmapped;
   endsequence

   a_reserved_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
      word_cfg_r[7:6] == 2'h0)
      else $error("word config reserved bits set");

   a_reserved_bit5: assert property (@(posedge ref_clk) disable iff (!rst_n)
      out_proto_r[5] == 1'b0)
      else $error("protocol bit 5 set");

   a_addr_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_wr_word |=> word_cfg_r == ($past(cfg_wdata) & `AOWLC_WORD_CFG_WMASK))
      else $error("word config write lost");

   a_addr_proto: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_wr_out_proto |=> out_proto_r == ($past(cfg_wdata) & `AOWLC_OUT_PROTO_WMASK))
      else $error("protocol config write lost");

   a_in_proto_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_wr_in_proto |=> in_proto_r == ($past(cfg_wdata) & `AOWLC_IN_PROTO_WMASK))
      else $error("input protocol write lost");

   a_unmapped_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_wr_unmapped |=> $stable(in_proto_r) && $stable(out_proto_r) && $stable(word_cfg_r))
      else $error("unmapped write changed a register");

   a_regs_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !cfg_wr |=> $stable(in_proto_r) && $stable(out_proto_r) && $stable(word_cfg_r))
      else $error("register changed without a write");

   a_rd_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !cfg_rd |-> cfg_rdata == 8'h00)
      else $error("read data driven while not reading");

   a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_rd && addr_unmapped |-> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_rd_word_resv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `AOWLC_ADDR_WORD_CFG |-> cfg_rdata[7:6] == 2'h0)
      else $error("word config reserved bits read high");

   a_rd_proto_resv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `AOWLC_ADDR_OUT_PROTO |-> cfg_rdata[5] == 1'b0)
      else $error("protocol bit 5 read high");

   a_rd_in_resv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_rd && cfg_addr == `AOWLC_ADDR_IN_PROTO |-> cfg_rdata[7:2] == 6'h00)
      else $error("input protocol reserved bits read high");

   // protocol, rate and lane decode; all of these lag the register by one edge
   a_rate_spi: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_protocol_select == `AOWLC_MODE_SPI |=> !double_rate)
      else $error("double rate in spi mode");

   a_rate_double: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_protocol_select == `AOWLC_MODE_SSYNC && out_proto_r[4] |=> double_rate)
      else $error("double rate not taken in source-sync mode");

   a_rate_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_protocol_select == `AOWLC_MODE_SSYNC && !out_proto_r[4] |=> !double_rate)
      else $error("single rate not kept in source-sync mode");

   a_ssync_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_protocol_select == `AOWLC_MODE_SSYNC |=> source_sync_mode)
      else $error("source sync not entered");

   a_ssync_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_protocol_select != `AOWLC_MODE_SSYNC |=> !source_sync_mode)
      else $error("source sync entered on another code");

   a_cpol_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> spi_cpol == $past(in_proto_r[1]))
      else $error("cpol mismatch");

   a_cpha_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> spi_cpha == $past(in_proto_r[0]))
      else $error("cpha mismatch");

   a_lane_zero_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> lane_enable[0])
      else $error("lane 0 not driven");

   a_lane_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_lane_count[1] == 1'b0 |=> lane_enable == 4'h1)
      else $error("extra lanes enabled");

   a_lane_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_lane_count == 2'h2 |=> lane_enable == 4'h3)
      else $error("two lane setting wrong");

   a_lane_four: assert property (@(posedge ref_clk) disable iff (!rst_n)
      output_lane_count == 2'h3 |=> lane_enable == 4'hF)
      else $error("not all lanes enabled");

   // output clock checks; each rate is judged only once the selection has been
   // steady long enough that every sampled out_clk value came from that choice; for the plain internal rate only the newest one
   sequence s_echo_sel;
      source_sync_mode && source_sync_clock_select == AOWLC_CLK_ECHO;
   endsequence
   sequence s_int_held;
      (source_sync_clock_select == AOWLC_CLK_INT) [*2];
   endsequence
   sequence s_div2_held;
      (source_sync_clock_select == AOWLC_CLK_INT_DIV2) [*4];
   endsequence
   sequence s_div4_held;
      (source_sync_clock_select == AOWLC_CLK_INT_DIV4) [*6];
   endsequence

   a_echo_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_echo_sel |=> out_clk_sel_echo)
      else $error("echo clock choice not flagged");

   a_echo_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !source_sync_mode |=> !out_clk_sel_echo)
      else $error("echo clock flagged outside source-sync mode");

   a_echo_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      source_sync_clock_select == AOWLC_CLK_ECHO |=> out_clk == $past(sclk_echo_in))
      else $error("echo clock not passed through");

   a_int_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_int_held |-> out_clk != $past(out_clk))
      else $error("internal clock not toggling every edge");

   a_div2_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_div2_held |->
      (out_clk ^ $past(out_clk)) != ($past(out_clk) ^ $past(out_clk, 2)))
      else $error("internal clock over two at wrong rate");

   a_div4_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_div4_held |-> $countones({out_clk ^ $past(out_clk),
                                  $past(out_clk) ^ $past(out_clk, 2),
                                  $past(out_clk, 2) ^ $past(out_clk, 3),
                                  $past(out_clk, 3) ^ $past(out_clk, 4)}) == 1)
      else $error("internal clock over four at wrong rate");
endmodule : aowlc_top

// ==== testbench/aowlc_host.sv ====
// host controller model: drives the strobed config port of the block
// assumes the bench calls its tasks; signals change on falling edges only
`timescale 1ns/1ps
`include "aowlc_defs.svh"
module aowlc_host (
   input  wire logic                     ref_clk,
   output logic                          cfg_wr,
   output logic                          cfg_rd,
   output logic      [`AOWLC_ADDR_W-1:0] cfg_addr,
   output logic      [7:0]               cfg_wdata,
   input  wire logic [7:0]               cfg_rdata
);
   // idle port at time zero
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = '0;
      cfg_wdata = 8'h00;
   end
   // one write; released lines show inverted values so stale data never looks valid
   task automatic wr(input logic [`AOWLC_ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == `AOWLC_ADDR_OUT_PROTO) begin
         v[5] = 1'b0;
         if (v[1:0] == 2'h1 || v[1:0] == 2'h2) v[1:0] = 2'h3;
      end
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = v;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      cfg_addr = ~cfg_addr;
      cfg_wdata = ~cfg_wdata;
   endtask : wr
   // one read; data taken at the rising edge while the request is held
   task automatic rd(input logic [`AOWLC_ADDR_W-1:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(posedge ref_clk);
      d = cfg_rdata;
      @(negedge ref_clk);
      cfg_rd = 1'b0;
      cfg_addr = ~cfg_addr;
   endtask : rd
endmodule : aowlc_host

// ==== testbench/tb_adc_output_word_and_lane_config.sv ====
// self-checking bench for the output word and lane configuration block
// assumes the host model drives the config port and out_word lags its inputs one edge
`timescale 1ns/1ps
`include "aowlc_defs.svh"
module tb_adc_output_word_and_lane_config;
   logic        ref_clk, nrst, cfg_wr, cfg_rd, sclk_echo_in, c;
   logic [8:0]  cfg_addr;
   logic [7:0]  cfg_wdata, cfg_rdata, rv, v;
   logic [15:0] conv_result;
   logic [19:0] out_word;
   logic [3:0]  lane_enable;
   logic        source_sync_mode, double_rate, out_clk_sel_echo, out_clk, spi_cpol, spi_cpha;
   logic [19:0] exp_q[$];
   int          miscompares, samples_checked, tg;
   aowlc_top dut (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .conv_result(conv_result), .sclk_echo_in(sclk_echo_in), .out_word(out_word),
      .lane_enable(lane_enable), .source_sync_mode(source_sync_mode),
      .double_rate(double_rate), .out_clk_sel_echo(out_clk_sel_echo), .out_clk(out_clk),
      .spi_cpol(spi_cpol), .spi_cpha(spi_cpha));
   aowlc_host host (.ref_clk(ref_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // expected word; span mask keeps only the chosen msbs
   function automatic logic [19:0] exp_word(input logic [5:0] k, input logic [15:0] r);
      logic [15:0] d;
      logic [15:0] m;
      d = r;
      if (k[2]) d = k[1] ? (k[0] ? `AOWLC_PAT_ALT2 : `AOWLC_PAT_ALT1)
                         : (k[0] ? `AOWLC_PAT_ONES : `AOWLC_PAT_ZEROS);
      m = 16'hFFFF << (12 - 4 * k[5:4]);
      return {d, k[3] & ^d, k[3] & ^(d & m), 2'b00};
   endfunction : exp_word
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_word(input logic [19:0] got, input logic [19:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic conclude;
      $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // watcher: oldest note against the word registered at this edge
   always @(posedge ref_clk) begin
      #1;
      if (exp_q.size() > 0) chk_word(out_word, exp_q.pop_front());
   end
   // echo clock level wanders freely
   always @(negedge ref_clk) sclk_echo_in <= 1'($urandom);
   // hang guard
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      conclude();
   end
   initial begin
      nrst = 1'b0;
      conv_result = 16'h0000;
      sclk_echo_in = 1'b0;
      tg = int'($urandom(32'h1EF4));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk_reg({4'h0, lane_enable}, 8'h01);
      // reset values and the unmapped slot below the bank
      for (int a = 0; a < 4; a++) begin
         host.rd(9'(9'h010 + 4 * a), rv);
         chk_reg(rv, 8'h00);
      end
      host.wr(9'h010, 8'hFF);
      host.rd(9'h010, rv);
      chk_reg(rv, 8'h00);
      for (int i = 0; i < 4; i++) begin
         host.wr(`AOWLC_ADDR_IN_PROTO, 8'(i));
         repeat (2) @(negedge ref_clk);
         chk_reg({6'h00, spi_cpol, spi_cpha}, 8'(i));
      end
      // every word setting, with read-only bits poked high
      for (int i = 0; i < 64; i++) begin
         host.wr(`AOWLC_ADDR_WORD_CFG, 8'(i) | 8'hC0);
         host.rd(`AOWLC_ADDR_WORD_CFG, rv);
         chk_reg(rv, 8'(i));
         repeat (4) begin
            @(negedge ref_clk);
            conv_result = 16'($urandom);
            exp_q.push_back(exp_word(6'(i), conv_result));
         end
      end
      @(negedge ref_clk);
      // every protocol setting in spi and source-sync modes
      for (int i = 0; i < 64; i++) begin
         v = {2'(i >> 4), 1'b1, 3'(i >> 1), i[0] ? 2'h3 : 2'h0};
         host.wr(`AOWLC_ADDR_OUT_PROTO, v);
         host.rd(`AOWLC_ADDR_OUT_PROTO, rv);
         chk_reg(rv, v & 8'hDF);
         @(negedge ref_clk);
         chk_reg({lane_enable, source_sync_mode, double_rate, out_clk_sel_echo, 1'b0},
            {i[2] ? (i[1] ? 4'hF : 4'h3) : 4'h1, i[0], i[0] & i[3],
             i[0] & (i[5:4] == 2'h0), 1'b0});
         if (i[0] && i[5:4] != 2'h0) begin
            tg = 0;
            repeat (8) begin
               c = out_clk;
               @(negedge ref_clk);
               if (out_clk !== c) tg++;
            end
            chk_reg(8'(tg), 8'(8 >> (i[5:4] - 1)));
         end else if (i[0]) begin
            chk_reg({7'h00, out_clk}, {7'h00, sclk_echo_in});
         end
      end
      conclude();
   end
endmodule : tb_adc_output_word_and_lane_config
